// >>> core/fscr_pkg.sv
// Overview of operation
// - security register reads, ignores all writes
// - security byte loaded during reset sequence
// - double fault on load sets all bits
// - backdoor key enabled only for 10
// - unsecured only when lock field 10
// - backdoor unlock forces lock field 10
// - index selects command object word
// - index register: only index bits live
// - factory test register reads zero, ignores writes
// - config: only bits 7,4,1,0 live
// - command done interrupt when enabled and flag
// - ignore bit suppresses single fault reporting
// - force double: every read sets flag
// - force single: every read sets flag unless ignore bit set
// - capture updates only on genuine faults
// - force bits stay until written zero
// - unforced: flags set only on real faults
// - done flag low while command executes
// - double fault interrupt when enabled and flag
package fscr_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] lock_state_register_off = 8'h01;
	localparam logic [7:0] command_word_index_off = 8'h02;
	localparam logic [7:0] factory_test_reserved_off = 8'h03;
	localparam logic [7:0] flash_config_control_off = 8'h04;
	localparam logic [7:0] command_status_register_off = 8'h05;
	localparam logic [7:0] error_config_register_off = 8'h06;
	localparam logic [7:0] error_status_register_off = 8'h07;

	// ==========================================================
	// field positions
	localparam int key_enable_hi = 7;
	localparam int key_enable_lo = 6;
	localparam int lock_field_hi = 1;
	localparam int lock_field_lo = 0;
	localparam int cmd_done_irq_enable_bit = 7;
	localparam int ignore_single_fault_bit = 4;
	localparam int force_double_fault_bit = 1;
	localparam int force_single_fault_bit = 0;
	localparam int cmd_done_flag_bit = 7;
	localparam int double_fault_bit = 1;
	localparam int single_fault_bit = 0;

	// ==========================================================
	// encodings and reset values
	localparam logic [1:0] field_open_code = 2'h2;
	localparam logic [7:0] lock_state_all_ones = 8'hff;
	localparam logic [7:0] lock_state_reset = 8'hff;
	localparam logic [7:0] config_reset = 8'h00;
	localparam logic [7:0] err_config_reset = 8'h00;
	localparam logic [7:0] err_status_reset = 8'h00;
	localparam logic [7:0] read_zero = 8'h00;

endpackage

// >>> core/fscr_regs.sv
`timescale 1ns/1ps
module fscr_regs
#(
	parameter int index_width = 3
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// security byte load during reset sequence
	input wire logic sec_load,
	input wire logic [7:0] sec_byte,
	input wire logic sec_load_dbl_fault,
	input wire logic backdoor_unlock,
	// command logic
	input wire logic cmd_busy,
	output logic [index_width-1:0] command_word_select,
	output logic secured,
	output logic backdoor_key_enabled,
	// array read path
	input wire logic array_rd,
	input wire logic array_dbl_err,
	input wire logic array_sgl_err,
	output logic ecc_capture_load,
	// interrupt requests
	output logic cmd_done_irq,
	output logic double_fault_irq,
	output logic single_fault_irq,
	// configuration levels
	output logic force_double_fault,
	output logic force_single_fault,
	output logic ignore_single_fault
);
	import fscr_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic field_is_open(input logic [1:0] f);
		field_is_open = (f == field_open_code);
	endfunction

	logic [7:0] lock_state_reg;
	logic [index_width-1:0] index_reg;
	logic [7:0] config_reg;
	logic [1:0] err_config_reg;
	logic [1:0] err_status_reg;
	logic cmd_done_flag;
	logic wr_config;
	logic wr_index;
	logic wr_err_config;
	logic wr_err_status;
	logic dbl_set;
	logic sgl_set;
	logic [7:0] rdata_next;
	logic [7:0] config_mask;

	assign config_mask = (8'h01 << cmd_done_irq_enable_bit)
		| (8'h01 << ignore_single_fault_bit)
		| (8'h01 << force_double_fault_bit)
		| (8'h01 << force_single_fault_bit);

	// ==========================================================
	// write decode
	always_comb
	begin
		wr_config = 1'b0;
		wr_index = 1'b0;
		wr_err_config = 1'b0;
		wr_err_status = 1'b0;
		if (reg_wr && reg_addr == flash_config_control_off)
			wr_config = 1'b1;
		else if (reg_wr && reg_addr == command_word_index_off)
			wr_index = 1'b1;
		else if (reg_wr && reg_addr == error_config_register_off)
			wr_err_config = 1'b1;
		else if (reg_wr && reg_addr == error_status_register_off)
			wr_err_status = 1'b1;
	end

	// ==========================================================
	// security register; software writes never reach it
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			lock_state_reg <= lock_state_reset;
		else if (sec_load)
		begin
			if (sec_load_dbl_fault)
				lock_state_reg <= lock_state_all_ones;
			else
				lock_state_reg <= sec_byte;
		end
		else if (backdoor_unlock)
			lock_state_reg[lock_field_hi:lock_field_lo] <=
				field_open_code;
	end

	// secured until loaded, so no window opens before the byte arrives
	assign secured = !field_is_open(
		lock_state_reg[lock_field_hi:lock_field_lo]);
	assign backdoor_key_enabled = field_is_open(
		lock_state_reg[key_enable_hi:key_enable_lo]);

	// ==========================================================
	// index register
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			index_reg <= '0;
		else if (wr_index)
			index_reg <= reg_wdata[index_width-1:0];
	end
	assign command_word_select = index_reg;

	// ==========================================================
	// configuration register
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			config_reg <= config_reset;
		else if (wr_config)
			config_reg <= reg_wdata & config_mask;
	end
	assign force_double_fault = config_reg[force_double_fault_bit];
	assign force_single_fault = config_reg[force_single_fault_bit];
	assign ignore_single_fault = config_reg[ignore_single_fault_bit];

	// ==========================================================
	// error interrupt enables
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			err_config_reg <= err_config_reset[1:0];
		else if (wr_err_config)
			err_config_reg <= reg_wdata[1:0];
	end

	// ==========================================================
	// fault flags; a set in the clear cycle wins
	assign dbl_set = array_rd
		&& (array_dbl_err || force_double_fault);
	// ignore hides forced and genuine single faults alike
	assign sgl_set = array_rd && !ignore_single_fault
		&& (array_sgl_err || force_single_fault);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			err_status_reg <= err_status_reset[1:0];
		else
		begin
			err_status_reg[double_fault_bit] <= dbl_set
				|| (err_status_reg[double_fault_bit]
				&& !(wr_err_status && reg_wdata[double_fault_bit]));
			err_status_reg[single_fault_bit] <= sgl_set
				|| (err_status_reg[single_fault_bit]
				&& !(wr_err_status && reg_wdata[single_fault_bit]));
		end
	end

	// capture follows only real faults, never forced ones
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			ecc_capture_load <= 1'b0;
		else
			ecc_capture_load <= array_rd && (array_dbl_err
				|| (array_sgl_err && !ignore_single_fault));
	end

	// ==========================================================
	// command done and interrupt requests
	assign cmd_done_flag = !cmd_busy;
	assign cmd_done_irq = config_reg[cmd_done_irq_enable_bit]
		&& cmd_done_flag;
	assign double_fault_irq = err_config_reg[double_fault_bit]
		&& err_status_reg[double_fault_bit];
	assign single_fault_irq = err_config_reg[single_fault_bit]
		&& err_status_reg[single_fault_bit];

	// ==========================================================
	// read mux, data one cycle after the strobe
	always_comb
	begin
		rdata_next = read_zero;
		if (reg_addr == lock_state_register_off)
			rdata_next = lock_state_reg;
		else if (reg_addr == command_word_index_off)
			rdata_next[index_width-1:0] = index_reg;
		else if (reg_addr == factory_test_reserved_off)
			rdata_next = read_zero;
		else if (reg_addr == flash_config_control_off)
			rdata_next = config_reg;
		else if (reg_addr == command_status_register_off)
			rdata_next[cmd_done_flag_bit] = cmd_done_flag;
		else if (reg_addr == error_config_register_off)
			rdata_next[1:0] = err_config_reg;
		else if (reg_addr == error_status_register_off)
			rdata_next[1:0] = err_status_reg;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= read_zero;
		else if (reg_rd)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= read_zero;
	end

endmodule

// >>> tb/flash_security_config_regs_tb.sv
`timescale 1ns/1ps
module flash_security_config_regs_tb;
	import fscr_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} fscr_row_s;
	logic core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, sec_byte = 8'h00, rdata;
	logic sec_load = 1'b0, dbl = 1'b0, unlock = 1'b0, busy = 1'b0, go = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [2:0] sel;
	logic sec, bke, ar, ad, as, cap, ic, id, is, fd, fs, ign;
	int err_count = 0, tests_run = 0;
	fscr_row_s rows [7] = '{'{8'h01, 8'h00, 8'hff}, '{8'h02, 8'hff, 8'h07},
		'{8'h03, 8'hff, 8'h00}, '{8'h04, 8'hff, 8'h93}, '{8'h04, 8'h00, 8'h00},
		'{8'h20, 8'hff, 8'h00}, '{8'h06, 8'h03, 8'h03}};
	fscr_regs i_dut (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata(rdata), .sec_load, .sec_byte,
		.sec_load_dbl_fault(dbl), .backdoor_unlock(unlock), .cmd_busy(busy),
		.command_word_select(sel), .secured(sec), .backdoor_key_enabled(bke),
		.array_rd(ar), .array_dbl_err(ad), .array_sgl_err(as),
		.ecc_capture_load(cap), .cmd_done_irq(ic), .double_fault_irq(id),
		.single_fault_irq(is), .force_double_fault(fd),
		.force_single_fault(fs), .ignore_single_fault(ign));
	fscr_flash_model i_far (.core_clk, .arst_n, .go, .kind, .array_rd(ar),
		.array_dbl_err(ad), .array_sgl_err(as));
	// ==========================================================
	// tasks
	task automatic chk(string n, logic [7:0] g, logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", rdata, e);
	endtask
	task automatic sl(logic [7:0] b, logic f);
		@(posedge core_clk);
		sec_load <= 1'b1;
		sec_byte <= b;
		dbl <= f;
		@(posedge core_clk);
		sec_load <= 1'b0;
		#1;
	endtask
	// one array read; cap is sampled in its pulse cycle
	task automatic ard(logic [1:0] k, logic e);
		@(posedge core_clk);
		go <= 1'b1;
		kind <= k;
		@(posedge core_clk);
		go <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("capture", {7'h0, cap}, {7'h0, e});
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================================
	// stimulus
	initial
		forever #4 core_clk = ~core_clk;
	initial
	begin
		#100000;
		err_count++;
		summarize();
	end
	initial
	begin
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		#1;
		chk("reset", {5'h0, sec, bke, ic}, 8'h04);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		chk("index", {5'h0, sel}, 8'h07);
		for (int i = 0; i < 4; i++)
		begin
			sl({i[1:0], 4'hf, i[1:0]}, 1'b0);
			chk("key", {7'h0, bke}, {7'h0, i == 2});
			chk("secured", {7'h0, sec}, {7'h0, i != 2});
			rd(8'h01, {i[1:0], 4'hf, i[1:0]});
		end
		sl(8'h82, 1'b1);
		rd(8'h01, 8'hff);
		@(posedge core_clk);
		unlock <= 1'b1;
		@(posedge core_clk);
		unlock <= 1'b0;
		rd(8'h01, 8'hfe);
		wr(8'h04, 8'h80);
		chk("done irq", {7'h0, ic}, 8'h01);
		@(posedge core_clk);
		busy <= 1'b1;
		#1;
		chk("busy irq", {7'h0, ic}, 8'h00);
		@(posedge core_clk);
		busy <= 1'b0;
		wr(8'h04, 8'h03);
		ard(2'h0, 1'b0);
		chk("irqs", {6'h0, id, is}, 8'h03);
		rd(8'h07, 8'h03);
		chk("force", {6'h0, fd, fs}, 8'h03);
		wr(8'h07, 8'h03);
		wr(8'h04, 8'h10);
		chk("ignore", {7'h0, ign}, 8'h01);
		ard(2'h1, 1'b0);
		rd(8'h07, 8'h00);
		wr(8'h04, 8'h00);
		ard(2'h2, 1'b1);
		rd(8'h07, 8'h02);
		summarize();
	end
endmodule

bind fscr_regs fscr_regs_props #(.index_width(index_width)) i_props (.*);

// >>> tb/fscr_flash_model.sv
`timescale 1ns/1ps
module fscr_flash_model
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic go,
	input wire logic [1:0] kind,
	output logic array_rd,
	output logic array_dbl_err,
	output logic array_sgl_err
);
	// ==========================================================
	// read path: error lines toggle when idle, never hold
	always @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			array_rd <= 1'b0;
			array_dbl_err <= 1'b0;
			array_sgl_err <= 1'b0;
		end
		else
		begin
			array_rd <= go;
			array_dbl_err <= go ? kind[1] : ~array_dbl_err;
			array_sgl_err <= go ? kind[0] : ~array_sgl_err;
		end
endmodule

// >>> tb/fscr_regs_properties.sv
`timescale 1ns/1ps
module fscr_regs_props
	import fscr_pkg::*;
#(
	parameter int index_width = 3
)
(
	// clock, reset, bus
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// security and command side
	input wire logic sec_load,
	input wire logic [7:0] sec_byte,
	input wire logic sec_load_dbl_fault,
	input wire logic backdoor_unlock,
	input wire logic cmd_busy,
	input wire logic [index_width-1:0] command_word_select,
	input wire logic secured,
	input wire logic backdoor_key_enabled,
	// array side
	input wire logic array_rd,
	input wire logic array_dbl_err,
	input wire logic array_sgl_err,
	input wire logic ecc_capture_load,
	input wire logic cmd_done_irq,
	input wire logic force_double_fault
);
	// ==========================================================
	// properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_lock_ro: assert property (reg_wr && reg_addr == lock_state_register_off
		&& !sec_load && !backdoor_unlock |=> $stable(secured)
		&& $stable(backdoor_key_enabled)) else $error("lock reg written");
	a_dbl_load: assert property (sec_load && sec_load_dbl_fault
		|=> secured && !backdoor_key_enabled) else $error("dbl load");
	a_key_dec: assert property (sec_load && !sec_load_dbl_fault |=>
		backdoor_key_enabled == ($past(sec_byte[7:6]) == field_open_code))
		else $error("key decode");
	a_lock_dec: assert property (sec_load && !sec_load_dbl_fault |=>
		secured == ($past(sec_byte[1:0]) != field_open_code))
		else $error("lock decode");
	a_unlock_force: assert property (backdoor_unlock && !sec_load
		|=> !secured) else $error("unlock");
	a_index_sel: assert property (reg_wr && reg_addr == command_word_index_off
		|=> command_word_select == $past(reg_wdata[index_width-1:0]))
		else $error("index");
	a_rsv_zero: assert property (reg_rd && reg_addr == factory_test_reserved_off
		|=> reg_rdata == read_zero) else $error("reserved");
	a_busy_irq: assert property (cmd_busy |-> !cmd_done_irq)
		else $error("done irq");
	a_cap_hold: assert property (array_rd && !array_dbl_err && !array_sgl_err
		|=> !ecc_capture_load) else $error("capture");
	a_force_hold: assert property (force_double_fault && !(reg_wr
		&& reg_addr == flash_config_control_off) |=> force_double_fault)
		else $error("force");
endmodule
